// ---- logic/xcvr_ctrl_pkg.sv ----
// Package of constants for the transceiver control and status contact logic
package xcvr_ctrl_pkg;
	// Rate boundary, in MBd: low select is at or below, high is above
	localparam int RateBoundaryMbd = 4250;
	localparam logic RateLow = 1'b0;
	localparam logic RateHigh = 1'b1;
	// Reset values of the registered outputs
	localparam logic FaultReset = 1'b0;
	localparam logic TxOffReset = 1'b1;
	localparam logic LostReset = 1'b0;
	localparam logic MissingReset = 1'b0;
	localparam logic SelReset = 1'b0;
	// Synchroniser depth
	localparam int SyncStages = 2;
	// Transmitter state machine, Gray coded
	typedef enum logic [1:0] {
		TX_HELD = 2'b00,
		TX_RUN = 2'b01,
		TX_OFF = 2'b11
	} tx_state_t;
endpackage

// ---- logic/sync_bus_if.sv ----
// Interface carrying raw contact levels into the synchroniser and back
`timescale 1ns/1ps
interface sync_bus_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport src (output raw, input synced);
	modport dst (input raw, output synced);
endinterface

// ---- logic/contact_sync.sv ----
// Two-stage synchroniser for asynchronous contact levels
`timescale 1ns/1ps
module contact_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	sync_bus_if.dst bus
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] stable_reg;
	logic [W-1:0] stable_next;

	always_comb begin
		meta_next = bus.raw;
		stable_next = meta_reg;
	end

	// First stage read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= INIT;
			stable_reg <= INIT;
		end else begin
			meta_reg <= meta_next;
			stable_reg <= stable_next;
		end
	end

	assign bus.synced = stable_reg;
endmodule

// ---- logic/xcvr_ctrl_status.sv ----
// Control and status contact logic of a pluggable optical transceiver
// Contract
// - Fault output high on laser fault detection, low otherwise.
// - Without fault reporting, fault output stays low permanently.
// - Transmitter-off high or floating turns the transmitter off.
// - Passive cable assembly may ignore the transmitter-off input.
// - Transmitter-off low means transmitter runs normally.
// - Rate-select inputs weakly pulled low; undriven reads low.
// - Receive rate select optionally chooses receive rate range.
// - Transmit rate select optionally chooses transmit rate range.
// - Alternate scheme maps contacts to alternate select lines zero, one.
// - Low selects rates up to 4.25 GBd; high selects above.
// - Module-missing reads high when no module is present.
// - Receive signal lost high when optical level is too low.
// - Without loss reporting on the contact, hold it low.
`timescale 1ns/1ps
module xcvr_ctrl_status #(
	parameter bit FAULT_SUPPORTED = 1'b1,
	parameter bit LOST_SUPPORTED = 1'b1,
	parameter bit LOST_ON_MGMT_ONLY = 1'b0,
	parameter bit PASSIVE_CABLE = 1'b0,
	parameter bit RX_RATE_SUPPORTED = 1'b1,
	parameter bit TX_RATE_SUPPORTED = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic transmitOffPin,
	input wire logic transmitOffDriven,
	input wire logic receiveRateSelectPin,
	input wire logic receiveRateSelectDriven,
	input wire logic transmitRateSelectPin,
	input wire logic transmitRateSelectDriven,
	input wire logic alternateSchemeEn,
	input wire logic laserFaultDetect,
	input wire logic opticalLevelLow,
	input wire logic modulePresent,
	output logic laserFaultOut,
	output logic laserFaultOe,
	output logic receiveSignalLostOut,
	output logic receiveSignalLostOe,
	output logic moduleMissing,
	output logic transmitterEnable,
	output logic receiveRateHigh,
	output logic transmitRateHigh,
	output logic alternateSelectZero,
	output logic alternateSelectOne
);
	// ****************************************************
	// Contact synchronisation
	// ****************************************************
	localparam int NumSync = 10;
	// Off contact starts floating and module present: held, no false absence
	localparam logic [NumSync-1:0] SyncInit = {1'b0,
		!xcvr_ctrl_pkg::MissingReset, 7'h00, xcvr_ctrl_pkg::TxOffReset};
	sync_bus_if #(.W(NumSync)) syncBus ();
	logic offPinS;
	logic offDrivenS;
	logic rxPinS;
	logic rxDrivenS;
	logic txPinS;
	logic txDrivenS;
	logic txOffS;
	logic rxSelS;
	logic txSelS;
	logic faultS;
	logic lowS;
	logic presentS;
	logic altS;

	assign syncBus.raw = {
		alternateSchemeEn,
		modulePresent,
		opticalLevelLow,
		laserFaultDetect,
		transmitRateSelectDriven,
		transmitRateSelectPin,
		receiveRateSelectDriven,
		receiveRateSelectPin,
		transmitOffDriven,
		transmitOffPin
	};

	contact_sync #(
		.W(NumSync),
		.INIT(SyncInit)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.bus(syncBus.dst)
	);

	assign {
		altS,
		presentS,
		lowS,
		faultS,
		txDrivenS,
		txPinS,
		rxDrivenS,
		rxPinS,
		offDrivenS,
		offPinS
	} = syncBus.synced;

	// ****************************************************
	// Contact resolution
	// ****************************************************
	// Resolved after both stages; a drive/level skew lasts one cycle only
	assign txOffS = offDrivenS ? offPinS : 1'b1;
	assign rxSelS = rxDrivenS & rxPinS;
	assign txSelS = txDrivenS & txPinS;

	// ****************************************************
	// Transmitter state
	// ****************************************************
	xcvr_ctrl_pkg::tx_state_t txState_reg;
	xcvr_ctrl_pkg::tx_state_t txState_next;

	always_comb begin
		txState_next = txState_reg;
		case (txState_reg)
			xcvr_ctrl_pkg::TX_HELD: begin
				if (PASSIVE_CABLE || !txOffS) begin
					txState_next = xcvr_ctrl_pkg::TX_RUN;
				end
			end
			xcvr_ctrl_pkg::TX_RUN: begin
				if (txOffS && !PASSIVE_CABLE) begin
					txState_next = xcvr_ctrl_pkg::TX_OFF;
				end
			end
			xcvr_ctrl_pkg::TX_OFF: begin
				if (!txOffS || PASSIVE_CABLE) begin
					txState_next = xcvr_ctrl_pkg::TX_RUN;
				end
			end
			default: begin
				txState_next = xcvr_ctrl_pkg::TX_HELD;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txState_reg <= xcvr_ctrl_pkg::TX_HELD;
		end else begin
			txState_reg <= txState_next;
		end
	end

	// ****************************************************
	// Status and rate outputs
	// ****************************************************
	logic fault_reg;
	logic fault_next;
	logic lost_reg;
	logic lost_next;
	logic missing_reg;
	logic missing_next;
	logic txEn_reg;
	logic txEn_next;
	logic rxRate_reg;
	logic rxRate_next;
	logic txRate_reg;
	logic txRate_next;
	logic alt0_reg;
	logic alt0_next;
	logic alt1_reg;
	logic alt1_next;

	always_comb begin
		fault_next = FAULT_SUPPORTED ? faultS : 1'b0;
		lost_next = (LOST_SUPPORTED && !LOST_ON_MGMT_ONLY) ? lowS : 1'b0;
		missing_next = !presentS;
		txEn_next = (txState_next == xcvr_ctrl_pkg::TX_RUN);
		// Alternate scheme takes both contacts off the rate paths
		rxRate_next = xcvr_ctrl_pkg::RateLow;
		txRate_next = xcvr_ctrl_pkg::RateLow;
		alt0_next = xcvr_ctrl_pkg::SelReset;
		alt1_next = xcvr_ctrl_pkg::SelReset;
		if (altS) begin
			alt0_next = rxSelS;
			alt1_next = txSelS;
		end else begin
			if (RX_RATE_SUPPORTED) begin
				rxRate_next = rxSelS;
			end
			if (TX_RATE_SUPPORTED) begin
				txRate_next = txSelS;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_reg <= xcvr_ctrl_pkg::FaultReset;
			lost_reg <= xcvr_ctrl_pkg::LostReset;
			missing_reg <= xcvr_ctrl_pkg::MissingReset;
			txEn_reg <= !xcvr_ctrl_pkg::TxOffReset;
			rxRate_reg <= xcvr_ctrl_pkg::SelReset;
			txRate_reg <= xcvr_ctrl_pkg::SelReset;
			alt0_reg <= xcvr_ctrl_pkg::SelReset;
			alt1_reg <= xcvr_ctrl_pkg::SelReset;
		end else begin
			fault_reg <= fault_next;
			lost_reg <= lost_next;
			missing_reg <= missing_next;
			txEn_reg <= txEn_next;
			rxRate_reg <= rxRate_next;
			txRate_reg <= txRate_next;
			alt0_reg <= alt0_next;
			alt1_reg <= alt1_next;
		end
	end

	// Open-drain contacts: enable pulls low, release lets host pull high
	assign laserFaultOut = 1'b0;
	assign laserFaultOe = !fault_reg;
	assign receiveSignalLostOut = 1'b0;
	assign receiveSignalLostOe = !lost_reg;
	assign moduleMissing = missing_reg;
	assign transmitterEnable = txEn_reg;
	assign receiveRateHigh = rxRate_reg;
	assign transmitRateHigh = txRate_reg;
	assign alternateSelectZero = alt0_reg;
	assign alternateSelectOne = alt1_reg;
endmodule

// ---- verification/xcvr_ctrl_checker.sv ----
// Checker of the transceiver contact logic ports
`timescale 1ns/1ps
module xcvr_ctrl_checker #(
	parameter bit FAULT_SUPPORTED = 1'b1,
	parameter bit LOST_SUPPORTED = 1'b1,
	parameter bit LOST_ON_MGMT_ONLY = 1'b0,
	parameter bit PASSIVE_CABLE = 1'b0,
	parameter bit RX_RATE_SUPPORTED = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic transmitOffPin,
	input wire logic transmitOffDriven,
	input wire logic receiveRateSelectPin,
	input wire logic receiveRateSelectDriven,
	input wire logic alternateSchemeEn,
	input wire logic laserFaultDetect,
	input wire logic opticalLevelLow,
	input wire logic modulePresent,
	input wire logic laserFaultOut,
	input wire logic laserFaultOe,
	input wire logic receiveSignalLostOut,
	input wire logic receiveSignalLostOe,
	input wire logic moduleMissing,
	input wire logic transmitterEnable,
	input wire logic receiveRateHigh
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_fSet;
		(FAULT_SUPPORTED && laserFaultDetect)[*4] |-> !laserFaultOe;
	endproperty
	a_fSet: assert property (p_fSet) else $error("fault set");
	property p_fHeld; !FAULT_SUPPORTED |-> laserFaultOe; endproperty
	a_fHeld: assert property (p_fHeld) else $error("fault held");
	property p_fClr;
		$fell(laserFaultDetect) ##0 !laserFaultDetect[*4] |-> laserFaultOe;
	endproperty
	a_fClr: assert property (p_fClr) else $error("fault clear");
	property p_fData; !laserFaultOut; endproperty
	a_fData: assert property (p_fData) else $error("fault data");
	property p_txOff;
		transmitterEnable && !PASSIVE_CABLE |->
			$past(transmitOffDriven, 3) && !$past(transmitOffPin, 3);
	endproperty
	a_txOff: assert property (p_txOff) else $error("tx off");
	property p_txOn;
		(transmitOffDriven && !transmitOffPin)[*4] |-> transmitterEnable;
	endproperty
	a_txOn: assert property (p_txOn) else $error("tx on");
	property p_txPass;
		PASSIVE_CABLE && $past(rst_n) |-> transmitterEnable;
	endproperty
	a_txPass: assert property (p_txPass) else $error("tx passive");
	property p_rx;
		(RX_RATE_SUPPORTED && receiveRateSelectDriven &&
			!alternateSchemeEn)[*4] |->
			receiveRateHigh == $past(receiveRateSelectPin, 3);
	endproperty
	a_rx: assert property (p_rx) else $error("rx rate");
	property p_miss; !modulePresent[*4] |-> moduleMissing; endproperty
	a_miss: assert property (p_miss) else $error("missing");
	property p_lost;
		$rose(opticalLevelLow) && LOST_SUPPORTED && !LOST_ON_MGMT_ONLY |->
			##3 !receiveSignalLostOe;
	endproperty
	a_lost: assert property (p_lost) else $error("lost");
	property p_lostHeld;
		LOST_ON_MGMT_ONLY || !LOST_SUPPORTED |-> receiveSignalLostOe;
	endproperty
	a_lostHeld: assert property (p_lostHeld) else $error("lost held");
	property p_lostData; !receiveSignalLostOut; endproperty
	a_lostData: assert property (p_lostData) else $error("lost data");
endmodule
bind xcvr_ctrl_status xcvr_ctrl_checker #(
	.FAULT_SUPPORTED(FAULT_SUPPORTED),
	.LOST_SUPPORTED(LOST_SUPPORTED),
	.LOST_ON_MGMT_ONLY(LOST_ON_MGMT_ONLY),
	.PASSIVE_CABLE(PASSIVE_CABLE),
	.RX_RATE_SUPPORTED(RX_RATE_SUPPORTED)
) checker_i (.*);

// ---- verification/host_contact_model.sv ----
// Host board controller model driving the module input contacts
`timescale 1ns/1ps
module host_contact_model (
	input wire logic offCmd,
	input wire logic rxCmd,
	input wire logic txCmd,
	input wire logic transmitOffDriven,
	input wire logic receiveRateSelectDriven,
	input wire logic transmitRateSelectDriven,
	output logic transmitOffPin,
	output logic receiveRateSelectPin,
	output logic transmitRateSelectPin
);
	// Released contact shows the inverse, so reading it gains nothing
	assign transmitOffPin = transmitOffDriven ? offCmd : !offCmd;
	assign receiveRateSelectPin =
		receiveRateSelectDriven ? rxCmd : !rxCmd;
	assign transmitRateSelectPin =
		transmitRateSelectDriven ? txCmd : !txCmd;
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the transceiver contact logic
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic offCmd = 1'b1, rxCmd = 1'b0, txCmd = 1'b0;
	logic transmitOffDriven = 1'b0, alternateSchemeEn = 1'b0;
	logic receiveRateSelectDriven = 1'b0, transmitRateSelectDriven = 1'b0;
	logic laserFaultDetect = 1'b0, opticalLevelLow = 1'b0;
	logic modulePresent = 1'b1;
	logic transmitOffPin, receiveRateSelectPin, transmitRateSelectPin;
	logic laserFaultOut, laserFaultOe, receiveSignalLostOut;
	logic receiveSignalLostOe, moduleMissing, transmitterEnable;
	logic receiveRateHigh, transmitRateHigh;
	logic alternateSelectZero, alternateSelectOne;
	logic optFaultOut, optFaultOe, optLostOut, optLostOe, optMissing;
	logic optTxEn, optRxHigh, optTxHigh, optSel0, optSel1;
	int nMismatch = 0;
	int checks = 0;
	always #2 clk = ~clk;
	host_contact_model HOST (.*);
	xcvr_ctrl_status DUT (.*);
	// Options off: no fault or loss contact, passive cable, fixed rates
	xcvr_ctrl_status #(
		.FAULT_SUPPORTED(1'b0),
		.LOST_SUPPORTED(1'b1),
		.LOST_ON_MGMT_ONLY(1'b1),
		.PASSIVE_CABLE(1'b1),
		.RX_RATE_SUPPORTED(1'b0),
		.TX_RATE_SUPPORTED(1'b0)
	) DUT_OPT (
		.clk(clk),
		.rst_n(rst_n),
		.transmitOffPin(transmitOffPin),
		.transmitOffDriven(transmitOffDriven),
		.receiveRateSelectPin(receiveRateSelectPin),
		.receiveRateSelectDriven(receiveRateSelectDriven),
		.transmitRateSelectPin(transmitRateSelectPin),
		.transmitRateSelectDriven(transmitRateSelectDriven),
		.alternateSchemeEn(alternateSchemeEn),
		.laserFaultDetect(laserFaultDetect),
		.opticalLevelLow(opticalLevelLow),
		.modulePresent(modulePresent),
		.laserFaultOut(optFaultOut),
		.laserFaultOe(optFaultOe),
		.receiveSignalLostOut(optLostOut),
		.receiveSignalLostOe(optLostOe),
		.moduleMissing(optMissing),
		.transmitterEnable(optTxEn),
		.receiveRateHigh(optRxHigh),
		.transmitRateHigh(optTxHigh),
		.alternateSelectZero(optSel0),
		.alternateSelectOne(optSel1)
	);
	task automatic chk(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			nMismatch++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	// Outputs lag the contacts by three edges
	task automatic settle;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#4000;
		nMismatch++;
		finish_test();
	end
	initial begin
		repeat (10) @(negedge clk);
		chk("fault", 1'b0, !laserFaultOe);
		rst_n = 1'b1;
		settle();
		chk("txEn", 1'b0, transmitterEnable);
		chk("optTxEn", 1'b1, optTxEn);
		transmitOffDriven = 1'b1;
		offCmd = 1'b0;
		settle();
		chk("txEn", 1'b1, transmitterEnable);
		for (int v = 1; v >= 0; v--) begin
			{offCmd, laserFaultDetect, opticalLevelLow} = {3{v[0]}};
			modulePresent = !v[0];
			settle();
			chk("txEn", !v[0], transmitterEnable);
			chk("fault", v[0], !laserFaultOe);
			chk("lost", v[0], !receiveSignalLostOe);
			chk("missing", v[0], moduleMissing);
			chk("optMissing", v[0], optMissing);
			chk("faultData", 1'b0, laserFaultOut);
			chk("lostData", 1'b0, receiveSignalLostOut);
			chk("optTxEn", 1'b1, optTxEn);
			chk("optFault", 1'b0, !optFaultOe);
			chk("optLost", 1'b0, !optLostOe);
		end
		for (int i = 0; i < 32; i++) begin
			{alternateSchemeEn, receiveRateSelectDriven, rxCmd,
				transmitRateSelectDriven, txCmd} = 5'(i);
			settle();
			chk("rxHigh", !i[4] && i[3] && i[2], receiveRateHigh);
			chk("txHigh", !i[4] && i[1] && i[0], transmitRateHigh);
			chk("sel0", i[4] && i[3] && i[2], alternateSelectZero);
			chk("sel1", i[4] && i[1] && i[0], alternateSelectOne);
			chk("optRx", 1'b0, optRxHigh);
			chk("optTx", 1'b0, optTxHigh);
			chk("optSel0", i[4] && i[3] && i[2], optSel0);
			chk("optSel1", i[4] && i[1] && i[0], optSel1);
		end
		// Reset in mid-run with the off contact driven low
		rst_n = 1'b0;
		@(negedge clk);
		chk("txEn", 1'b0, transmitterEnable);
		chk("optTxEn", 1'b0, optTxEn);
		chk("fault", 1'b0, !laserFaultOe);
		rst_n = 1'b1;
		settle();
		chk("txEn", 1'b1, transmitterEnable);
		chk("optTxEn", 1'b1, optTxEn);
		finish_test();
	end
endmodule
